/* hw/rcd_pkg.sv */
// constants shared by the regional clock divider and its hold-off line
// assumes one clock, pclk, with every input synchronous to it
//
// What this block does
// - divide setting picks an integer ratio one to eight for the output clock
// - divide setting defaults to bypass, passing the input clock undivided
// - enable and clear have no effect while bypass is selected
// - clear resets divider state and forces the output low while set
// - enable changes take effect four input clock cycles after the transition
// - output stays static while global set/reset is high, whatever the enable, except in bypass
// - output starts toggling four input cycles after global set/reset release
// - odd ratios of three and above make the low phase one input cycle longer than high
// - every integer ratio, ratio one included, keeps the same edge alignment
// - clear release with enable active resumes the divided rate at once
// - io clock buffer passes its input clock straight to its output
package rcd_pkg;

    // ==========================================================
    // register map
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;

    // control register fields
    localparam int CTRL_DIV_LSB   = 0;
    localparam int CTRL_DIV_MSB   = 3;
    localparam int CTRL_ENABLE    = 4;
    localparam int CTRL_CLEAR     = 5;
    localparam int CTRL_GSR       = 6;

    // status register fields
    localparam int STAT_EN_EFF    = 0;
    localparam int STAT_GSR_OK    = 1;
    localparam int STAT_OUT       = 2;
    localparam int STAT_CNT_LSB   = 3;
    localparam int STAT_CNT_MSB   = 5;

    // ==========================================================
    // divide setting encoding and reset values
    localparam logic [3:0] DIV_BYPASS     = 4'h0;
    localparam logic [3:0] DIV_ONE        = 4'h1;
    localparam logic [3:0] DIV_MAX        = 4'h8;
    localparam logic [3:0] DIV_RESET      = DIV_BYPASS;
    localparam logic       ENABLE_RESET   = 1'b0;
    localparam logic       CLEAR_RESET    = 1'b0;
    localparam logic       GSR_RESET      = 1'b0;

    // ==========================================================
    // latency of enable and set/reset release, in input clock cycles
    localparam int HOLD_CYCLES = 4;

endpackage

/* hw/rcd_hold_line.sv */
// delay line counted in input clock cycles, used for enable and set/reset release
// assumes step pulses once per input clock rising edge, all synchronous to pclk
`timescale 1ns/1ns
module rcd_hold_line (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    input  wire logic step,
    input  wire logic clear,
    input  wire logic level_in,
    output logic      level_out
);

    typedef struct packed {
        logic [rcd_pkg::HOLD_CYCLES-1:0] taps;
    } rcd_hold_state_type;

    rcd_hold_state_type state_q;
    rcd_hold_state_type state_d;

    // ==========================================================
    // next state
    always_comb begin
        state_d = state_q;
        // clear empties the line at once so a short pulse still restarts the wait
        if (clear) begin
            state_d.taps = '0;
        end else if (step) begin
            state_d.taps = {state_q.taps[rcd_pkg::HOLD_CYCLES-2:0], level_in};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    assign level_out = state_q.taps[rcd_pkg::HOLD_CYCLES-1];

endmodule

/* hw/rcd_divider.sv */
// regional clock buffer with integer divider, plus the plain io clock buffer
// assumes src_clk is a slow clock sampled by pclk; each rising edge seen is one input cycle
`timescale 1ns/1ns
module rcd_divider (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        src_clk,
    output logic             regional_clk_out,
    input  wire logic        io_clk_in,
    output logic             io_clk_out
);

    typedef struct packed {
        logic        src_prev;
        logic [2:0]  cnt;
        logic        out;
        logic [3:0]  divide;
        logic        enable;
        logic        clear;
        logic        global_set_reset;
        logic [31:0] rdata;
        logic        err;
    } rcd_state_type;

    rcd_state_type state_q;
    rcd_state_type state_d;

    logic       rise;
    logic       bypass;
    logic       en_eff;
    logic       gsr_ok;
    logic       running;
    logic [2:0] half;
    logic [2:0] last;
    logic       wr_ok;

    // ==========================================================
    // io clock buffer
    assign io_clk_out = io_clk_in;

    // ==========================================================
    // input edge and derived controls
    assign rise   = src_clk & ~state_q.src_prev;
    assign bypass = (state_q.divide == rcd_pkg::DIV_BYPASS);
    assign half   = state_q.divide[3:1];
    assign last   = 3'(state_q.divide - 4'h1);

    rcd_hold_line u_enable_line (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .step      (rise),
        .clear     (1'b0),
        .level_in  (state_q.enable),
        .level_out (en_eff)
    );

    // set/reset empties the line, so release waits a full four input cycles
    rcd_hold_line u_gsr_line (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .step      (rise),
        .clear     (state_q.global_set_reset),
        .level_in  (1'b1),
        .level_out (gsr_ok)
    );

    assign running = en_eff & gsr_ok & ~state_q.global_set_reset & ~state_q.clear;

    // ==========================================================
    // apb decode
    assign wr_ok = (pwdata[rcd_pkg::CTRL_DIV_MSB:rcd_pkg::CTRL_DIV_LSB] <= rcd_pkg::DIV_MAX);

    // ==========================================================
    // next state
    always_comb begin
        state_d = state_q;
        state_d.src_prev = src_clk;

        // divider
        if (bypass || !running) begin
            // stopped output sits low and the count restarts from zero
            state_d.cnt = 3'h0;
            state_d.out = 1'b0;
        end else if (state_q.divide == rcd_pkg::DIV_ONE) begin
            // same single register stage as the divided path keeps edges aligned
            state_d.out = src_clk;
        end else if (rise) begin
            state_d.out = (state_q.cnt < half);
            state_d.cnt = (state_q.cnt == last) ? 3'h0 : 3'(state_q.cnt + 3'h1);
        end

        // setup phase: capture read data so the access phase answers from flops
        if (psel && !penable) begin
            state_d.rdata = 32'h0000_0000;
            state_d.err   = 1'b0;
            if (paddr == rcd_pkg::CTRL_OFFSET) begin
                state_d.rdata[rcd_pkg::CTRL_DIV_MSB:rcd_pkg::CTRL_DIV_LSB] = state_q.divide;
                state_d.rdata[rcd_pkg::CTRL_ENABLE] = state_q.enable;
                state_d.rdata[rcd_pkg::CTRL_CLEAR]  = state_q.clear;
                state_d.rdata[rcd_pkg::CTRL_GSR]    = state_q.global_set_reset;
                state_d.err = pwrite & ~wr_ok;
            end else if (paddr == rcd_pkg::STATUS_OFFSET) begin
                state_d.rdata[rcd_pkg::STAT_EN_EFF] = en_eff;
                state_d.rdata[rcd_pkg::STAT_GSR_OK] = gsr_ok;
                state_d.rdata[rcd_pkg::STAT_OUT]    = state_q.out;
                state_d.rdata[rcd_pkg::STAT_CNT_MSB:rcd_pkg::STAT_CNT_LSB] = state_q.cnt;
                state_d.err = pwrite;
            end else begin
                state_d.err = 1'b1;
            end
        end

        // access phase: write takes effect at the completing edge
        if (psel && penable && pwrite && !state_q.err && paddr == rcd_pkg::CTRL_OFFSET) begin
            state_d.divide = pwdata[rcd_pkg::CTRL_DIV_MSB:rcd_pkg::CTRL_DIV_LSB];
            state_d.enable = pwdata[rcd_pkg::CTRL_ENABLE];
            state_d.clear  = pwdata[rcd_pkg::CTRL_CLEAR];
            state_d.global_set_reset    = pwdata[rcd_pkg::CTRL_GSR];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q        <= '0;
            state_q.divide <= rcd_pkg::DIV_RESET;
            state_q.enable <= rcd_pkg::ENABLE_RESET;
            state_q.clear  <= rcd_pkg::CLEAR_RESET;
            state_q.global_set_reset    <= rcd_pkg::GSR_RESET;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // outputs
    // bypass ignores enable, clear and set/reset entirely
    assign regional_clk_out = bypass ? src_clk : (state_q.out & ~state_q.clear & ~state_q.global_set_reset);
    assign prdata  = state_q.rdata;
    assign pslverr = state_q.err & psel & penable;
    assign pready  = 1'b1;

endmodule

/* dv/rcd_src_model.sv */
// source clock and io clock model feeding the divider
// assumes pclk runs free; src_clk period is 2*HALF pclk cycles
`timescale 1ns/1ns
module rcd_src_model #(parameter int HALF = 2) (
    input  wire logic pclk,
    output logic      src_clk,
    output logic      io_clk_in
);
    // ==========
    // clocks run free, so no idle level is needed
    int n = 0;
    initial src_clk = 1'b0;
    initial io_clk_in = 1'b0;
    always @(posedge pclk) begin
        n <= (n == HALF - 1) ? 0 : n + 1;
        if (n == HALF - 1)
            src_clk <= ~src_clk;
        io_clk_in <= ~io_clk_in;
    end
endmodule

/* dv/rcd_divider_checker.sv */
// port assertions for the regional clock divider
// assumes it is bound into rcd_divider
`timescale 1ns/1ns
module rcd_divider_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        src_clk,
    input wire logic        regional_clk_out,
    input wire logic        io_clk_in,
    input wire logic        io_clk_out
);
    // ==========
    // shadow of accepted control writes
    logic [31:0] ctrl_q;
    wire         acc = psel & penable;
    wire         div = ctrl_q[3:0] != 4'h0;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ctrl_q <= '0;
        else if (acc && pwrite && paddr == rcd_pkg::CTRL_OFFSET && pwdata[3:0] <= rcd_pkg::DIV_MAX)
            ctrl_q <= pwdata;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_io; io_clk_out == io_clk_in; endproperty
    a_io: assert property (p_io) else $error("io clock differs");
    property p_rdy; acc |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_unm; acc && paddr > 12'h004 |-> pslverr; endproperty
    a_unm: assert property (p_unm) else $error("unmapped not refused");
    property p_ro; acc && pwrite && paddr == rcd_pkg::STATUS_OFFSET |-> pslverr; endproperty
    a_ro: assert property (p_ro) else $error("status write not refused");
    property p_rng; acc && pwrite && paddr == 12'h000 && pwdata[3:0] > 4'h8 |-> pslverr; endproperty
    a_rng: assert property (p_rng) else $error("bad ratio not refused");
    property p_byp; !div |-> regional_clk_out == src_clk; endproperty
    a_byp: assert property (p_byp) else $error("bypass not passing");
    property p_clr; div && ctrl_q[5] |-> !regional_clk_out; endproperty
    a_clr: assert property (p_clr) else $error("output high in clear");
    property p_gsr; div && ctrl_q[6] |-> !regional_clk_out; endproperty
    a_gsr: assert property (p_gsr) else $error("output toggles in hold");
    property p_res; div && ctrl_q[4] && !ctrl_q[6] && $fell(ctrl_q[5]) |-> ##[1:40] regional_clk_out; endproperty
    a_res: assert property (p_res) else $error("no resume after clear");
endmodule
bind rcd_divider rcd_divider_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .src_clk, .regional_clk_out, .io_clk_in, .io_clk_out);

/* dv/test_regional_clock_divider.sv */
// self-checking bench for the regional clock divider
// assumes the source model and the bound checker
`timescale 1ns/1ns
module test_regional_clock_divider;
    // ==========
    localparam int PER = 4;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clk_en = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, src_clk, io_clk_in, regional_clk_out, io_clk_out, sp;
    int          num_errors = 0, total_checks = 0, c, r, cur;
    always #4 pclk = ~pclk;
    rcd_src_model #(.HALF(PER / 2)) i_src (.pclk, .src_clk, .io_clk_in);
    rcd_divider i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .src_clk, .regional_clk_out, .io_clk_in, .io_clk_out);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // waits for ready as long as it takes; only the watchdog ends a hung transfer
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wctl(input logic [31:0] d);
        xfer(1'b1, rcd_pkg::CTRL_OFFSET, d);
    endtask
    // counts pclk cycles and source rises until the output reaches lvl
    task automatic wait_out(input logic lvl, input int lim);
        c = 0;
        r = 0;
        sp = src_clk;
        // first look is half a cycle on, once the edge that ended the last write has settled
        do begin
            @(negedge pclk);
            r += int'(src_clk && !sp);
            sp = src_clk;
            c++;
        end while (regional_clk_out !== lvl && c < lim);
    endtask
    task automatic close_out;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, rcd_pkg::CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 12'h008, 32'h0);
        chk(32'(er), 32'h1);
        xfer(1'b1, rcd_pkg::STATUS_OFFSET, 32'h1);
        chk(32'(er), 32'h1);
        wctl(32'h19);
        chk(32'(er), 32'h1);
        xfer(1'b0, rcd_pkg::CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0);
        wctl(32'h20);
        repeat (8) begin
            @(negedge pclk);
            chk(32'(regional_clk_out), 32'(src_clk));
        end
        wctl(32'h02);
        wctl(32'h12);
        wait_out(1'b1, 400);
        chk(32'(r >= 4 && r <= 5), 32'h1);
        wctl(32'h52);
        wait_out(1'b1, 12 * PER);
        chk(c, 12 * PER);
        wctl(32'h12);
        wait_out(1'b1, 400);
        chk(32'(r >= 4 && r <= 5), 32'h1);
        cur = 2;
        for (int n = 2; n <= 8; n++) begin
            wctl(32'h30 | cur);
            wctl(32'h30 | n);
            @(negedge pclk);
            chk(32'(regional_clk_out), 32'h0);
            wctl(32'h10 | n);
            wait_out(1'b1, 400);
            chk(r, 1);
            wait_out(1'b0, 400);
            chk(c, PER * (n / 2));
            wait_out(1'b1, 400);
            chk(c, PER * (n - n / 2));
            cur = n;
        end
        wctl(32'h38);
        wctl(32'h31);
        wctl(32'h11);
        wait_out(1'b1, 400);
        repeat (8) begin
            @(negedge pclk);
            chk(32'(regional_clk_out), 32'(sp));
            sp = src_clk;
        end
        // a low clock enable freezes the running divider, so the output holds its level
        @(posedge pclk);
        clk_en <= 1'b0;
        @(negedge pclk);
        sp = regional_clk_out;
        repeat (8) begin
            @(negedge pclk);
            chk(32'(regional_clk_out), 32'(sp));
        end
        @(posedge pclk);
        clk_en <= 1'b1;
        close_out;
    end
    initial begin
        #200000;
        num_errors++;
        close_out;
    end
endmodule
